//--- l2dm_defs.vh
`ifndef L2DM_DEFS_VH
`define L2DM_DEFS_VH
// byte offsets on the register bus
`define L2DM_KEY_BASE 20'h80000
`define L2DM_KEY_TOP 20'ha0000
`define L2DM_LPORT_BASE 20'hc4500
`define L2DM_LMASK_HI 20'hc4648
`define L2DM_LMASK_LO 20'hc464c
`define L2DM_DENY_HI 20'hc4650
`define L2DM_DENY_LO 20'hc4654
`define L2DM_SMIR_HI 20'hc4658
`define L2DM_SMIR_LO 20'hc465c
`define L2DM_LEARN_PORT 20'hc4668
`define L2DM_MIRROR_PORT 20'hc466c
`define L2DM_SUP_PORT 20'hc4674
`define L2DM_USER_PORT 20'hc4678
`define L2DM_SNOOP_PORT 20'hc467c
`define L2DM_NODEST_CNT 20'hc4680
`define L2DM_IGMP_PORT 20'hc4684
`define L2DM_MIRROR_CTRL 20'hc4688
`define L2DM_MODE_BASE 20'hc4700
// table sizes
`define L2DM_KEY_RECS 4096
`define L2DM_LPORT_RECS 52
`define L2DM_MODE_RECS 61
// port map layout
`define L2DM_MAP_W 58
`define L2DM_XG_FIRST 48
`define L2DM_SU_FIRST 50
// fields
`define L2DM_VALID_BIT 31
`define L2DM_PERMIT_BIT 23
`define L2DM_SPORT_LSB 17
`define L2DM_DISC_BIT 3
`define L2DM_SUPR_BIT 2
`define L2DM_USNP_BIT 1
`define L2DM_IGMP_BIT 0
`define L2DM_CNT_W 28
// reset values
`define L2DM_RST_MASK 58'h0
`define L2DM_RST_PORT 6'h00
`define L2DM_RST_CNT 28'h0
`endif

//--- l2dm_post.v
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "l2dm_defs.vh"

// Notes on behaviour
// - 4096 two-key records; matching key's result selected
// - learning state clears learning-mask destinations
// - map bits: 0-47 gig, 48-49 10G, 50-57 supervisor
// - unknown or moved source copied to learning target
// - physical port indexes 52-entry logical port table
// - aggregate members share one logical identity
// - mirrored rx/tx packets copied to mirror target
// - discard unknown sources when per-port bit set
// - known source and dest, VLAN mismatch: gig/10G bits cleared before copies
// - per-port bit gates user TCP port snooping
// - per-port bit gates IGMP copy to supervisor
// - 61 per-port mode records, table-indexed
// - 28-bit counter counts empty final maps
// - source deny removes deny-mask ports
// - 58-bit source mirror selection register
// - rx port bit in mirror map copies packet
// - known source and dest, VLAN mismatch adds supervisor route port
// - matching TCP port adds snooping port
module l2dm_post (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rstn,
    // register bus
    input wire [19:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // packet from look-up stages
    input wire i_pkt_valid,
    input wire [5:0] i_pkt_rx_port,
    input wire [11:0] i_pkt_rec_idx,
    input wire [47:0] i_pkt_src_addr,
    input wire [57:0] i_pkt_dest_map,
    input wire i_pkt_src_deny,
    input wire i_pkt_learning,
    input wire i_pkt_dest_known,
    input wire i_pkt_vlan_mismatch,
    input wire i_pkt_tx_mirror,
    input wire i_pkt_igmp,
    input wire i_pkt_tcp_valid,
    input wire [15:0] i_pkt_tcp_dport,
    // packet to queueing
    output reg o_pkt_valid,
    output reg [57:0] o_pkt_dest_map,
    output reg [5:0] o_pkt_logical_port,
    output reg o_pkt_src_found,
    output reg o_pkt_src_permit,
    output reg o_pkt_discard
);

    reg [47:0] key0 [0:`L2DM_KEY_RECS-1];
    reg [47:0] key1 [0:`L2DM_KEY_RECS-1];
    reg kval0 [0:`L2DM_KEY_RECS-1];
    reg kval1 [0:`L2DM_KEY_RECS-1];
    reg [31:0] res0 [0:`L2DM_KEY_RECS-1];
    reg [31:0] res1 [0:`L2DM_KEY_RECS-1];
    reg [5:0] lport_tab [0:`L2DM_LPORT_RECS-1];
    reg [3:0] mode_tab [0:`L2DM_MODE_RECS-1];

    reg [57:0] learn_mask;
    reg [57:0] deny_mask;
    reg [57:0] src_mirror;
    reg [5:0] learn_port;
    reg [5:0] mirror_port;
    reg [5:0] sup_port;
    reg [15:0] user_port;
    reg [5:0] snoop_port;
    reg [5:0] igmp_port;
    reg mirror_en;
    reg [27:0] nodest_cnt;
    reg ack;

    reg [31:0] rd_mux;
    wire [31:0] wr_val;
    reg [57:0] next_map;
    reg next_found;
    reg next_permit;
    reg next_discard;
    reg [5:0] next_lport;
    reg [31:0] hit_res;
    reg [3:0] pmode;

    wire [19:0] a = i_avs_address;
    wire key_sel = (a >= `L2DM_KEY_BASE) && (a < `L2DM_KEY_TOP);
    wire [11:0] rec = a[16:5];
    wire [2:0] kw = a[4:2];
    wire lport_sel = (a >= `L2DM_LPORT_BASE) && (a < `L2DM_LPORT_BASE + 20'd208);
    wire [5:0] lidx = a[7:2];
    wire mode_sel = (a >= `L2DM_MODE_BASE) && (a < `L2DM_MODE_BASE + 20'd244);
    wire [5:0] midx = a[7:2];
    wire wr_go = i_avs_write & ack;
    integer i;

    // both keys of the indexed record are compared in parallel; key0 wins a double hit
    // so a stale duplicate left in key1 cannot change the answer
    wire hit0 = kval0[i_pkt_rec_idx] && (key0[i_pkt_rec_idx] == i_pkt_src_addr);
    wire hit1 = kval1[i_pkt_rec_idx] && (key1[i_pkt_rec_idx] == i_pkt_src_addr);

    // tables and single registers share one decode; an address that hits neither a
    // table window nor a named register reads zero and drops the write
    // the table windows are checked first, so a named register can never sit inside one

    // one wait cycle per access; request is taken when waitrequest is low
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;

    // set a port bit only for numbers that exist in the map
    function [57:0] l2dm_bit;
        input [5:0] p;
        begin
            l2dm_bit = (p < 6'd58) ? (58'h1 << p) : 58'h0;
        end
    endfunction

    // table-indexing port number to map bit position
    // the two numbering schemes differ only for the 10G ports and supervisor queues:
    // tables index them as 48/49 (supervisor) and 50/60 (10G), maps place 10G at 48/49
    // and supervisor at 50/51; unused numbers map to 63, which selects no bit
    function [5:0] l2dm_map_pos;
        input [5:0] t;
        begin
            if (t < 6'd48)
                l2dm_map_pos = t;
            else if (t == 6'd48 || t == 6'd49)
                l2dm_map_pos = t + 6'd2;
            else if (t == 6'd50)
                l2dm_map_pos = 6'd48;
            else if (t == 6'd60)
                l2dm_map_pos = 6'd49;
            else
                l2dm_map_pos = 6'd63;
        end
    endfunction

    // receive port position in the source mirror map; out-of-map numbers never mirror
    wire [5:0] rx_pos = l2dm_map_pos(i_pkt_rx_port);
    wire rx_mirrored = (rx_pos < 6'd58) && src_mirror[rx_pos];

    // register read mux
    // mask registers show their upper six bits as zero so a read-modify-write by
    // software cannot set bits beyond the 58 ports
    // key words 6 and 7 of a record have no storage and read zero
    always @* begin
        rd_mux = 32'h0;
        if (key_sel) begin
            case (kw)
                3'd0: rd_mux = {kval0[rec], 15'h0, key0[rec][47:32]};
                3'd1: rd_mux = key0[rec][31:0];
                3'd2: rd_mux = {kval1[rec], 15'h0, key1[rec][47:32]};
                3'd3: rd_mux = key1[rec][31:0];
                3'd4: rd_mux = res0[rec];
                3'd5: rd_mux = res1[rec];
                default: rd_mux = 32'h0;
            endcase
        end else if (lport_sel) begin
            rd_mux = {26'h0, lport_tab[lidx]};
        end else if (mode_sel) begin
            rd_mux = {28'h0, mode_tab[midx]};
        end else begin
            case (a)
                `L2DM_LMASK_HI: rd_mux = {6'h0, learn_mask[57:32]};
                `L2DM_LMASK_LO: rd_mux = learn_mask[31:0];
                `L2DM_DENY_HI: rd_mux = {6'h0, deny_mask[57:32]};
                `L2DM_DENY_LO: rd_mux = deny_mask[31:0];
                `L2DM_SMIR_HI: rd_mux = {6'h0, src_mirror[57:32]};
                `L2DM_SMIR_LO: rd_mux = src_mirror[31:0];
                `L2DM_LEARN_PORT: rd_mux = {26'h0, learn_port};
                `L2DM_MIRROR_PORT: rd_mux = {26'h0, mirror_port};
                `L2DM_SUP_PORT: rd_mux = {26'h0, sup_port};
                `L2DM_USER_PORT: rd_mux = {16'h0, user_port};
                `L2DM_SNOOP_PORT: rd_mux = {26'h0, snoop_port};
                `L2DM_IGMP_PORT: rd_mux = {26'h0, igmp_port};
                `L2DM_MIRROR_CTRL: rd_mux = {31'h0, mirror_en};
                `L2DM_NODEST_CNT: rd_mux = {4'h0, nodest_cnt};
                default: rd_mux = 32'h0;
            endcase
        end
    end

    // byte enables merge into the current value, so partial writes keep other lanes;
    // the registers store only their used bits, so a lane holding unused bits stays zero
    // whatever is written to it
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            assign wr_val[lane*8 +: 8] = i_avs_byteenable[lane] ?
                i_avs_writedata[lane*8 +: 8] : rd_mux[lane*8 +: 8];
        end
    endgenerate

    // bus handshake and readback
    // ack is high for exactly one cycle per request; because it clears itself the
    // next cycle, a master that keeps its request up starts a fresh access rather than
    // seeing a second acknowledge for the same one
    // readdata is captured in the wait cycle and then held until the next read
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack <= 1'b0;
            o_avs_readdata <= 32'h0;
        end else begin
            ack <= (i_avs_read | i_avs_write) & ~ack;
            if (i_avs_read & ~ack)
                o_avs_readdata <= rd_mux;
        end
    end

    // key tables are not reset; software loads them before traffic
    // clearing 4096 records would need a sweep engine or a large reset fan-out; an
    // unloaded record reads back unknown, and a packet indexing it gives an unknown map
    always @(posedge i_ref_clk) begin
        if (wr_go && key_sel) begin
            case (kw)
                3'd0: begin
                    kval0[rec] <= wr_val[`L2DM_VALID_BIT];
                    key0[rec][47:32] <= wr_val[15:0];
                end
                3'd1: key0[rec][31:0] <= wr_val;
                3'd2: begin
                    kval1[rec] <= wr_val[`L2DM_VALID_BIT];
                    key1[rec][47:32] <= wr_val[15:0];
                end
                3'd3: key1[rec][31:0] <= wr_val;
                3'd4: res0[rec] <= wr_val;
                3'd5: res1[rec] <= wr_val;
                default: ;
            endcase
        end
    end

    // per-port tables
    // both tables reset to zero: every port below 52 starts as logical port 0 with all
    // per-port options off, so software must load identities before learning starts
    // only the low bits are stored; the rest of each record reads zero
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (i = 0; i < `L2DM_LPORT_RECS; i = i + 1)
                lport_tab[i] <= `L2DM_RST_PORT;
            for (i = 0; i < `L2DM_MODE_RECS; i = i + 1)
                mode_tab[i] <= 4'h0;
        end else if (wr_go) begin
            if (lport_sel)
                lport_tab[lidx] <= wr_val[5:0];
            if (mode_sel)
                mode_tab[midx] <= wr_val[3:0];
        end
    end

    // single configuration registers
    // 58-bit masks are written as two words; between the two writes a packet sees
    // half old and half new mask, which software avoids by writing while idle
    // port registers other than user_port keep six bits; a number of 58 or more selects no destination
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            learn_mask <= `L2DM_RST_MASK;
            deny_mask <= `L2DM_RST_MASK;
            src_mirror <= `L2DM_RST_MASK;
            learn_port <= `L2DM_RST_PORT;
            mirror_port <= `L2DM_RST_PORT;
            sup_port <= `L2DM_RST_PORT;
            user_port <= 16'h0;
            snoop_port <= `L2DM_RST_PORT;
            igmp_port <= `L2DM_RST_PORT;
            mirror_en <= 1'b0;
        end else if (wr_go) begin
            case (a)
                `L2DM_LMASK_HI: learn_mask[57:32] <= wr_val[25:0];
                `L2DM_LMASK_LO: learn_mask[31:0] <= wr_val;
                `L2DM_DENY_HI: deny_mask[57:32] <= wr_val[25:0];
                `L2DM_DENY_LO: deny_mask[31:0] <= wr_val;
                `L2DM_SMIR_HI: src_mirror[57:32] <= wr_val[25:0];
                `L2DM_SMIR_LO: src_mirror[31:0] <= wr_val;
                `L2DM_LEARN_PORT: learn_port <= wr_val[5:0];
                `L2DM_MIRROR_PORT: mirror_port <= wr_val[5:0];
                `L2DM_SUP_PORT: sup_port <= wr_val[5:0];
                `L2DM_USER_PORT: user_port <= wr_val[15:0];
                `L2DM_SNOOP_PORT: snoop_port <= wr_val[5:0];
                `L2DM_IGMP_PORT: igmp_port <= wr_val[5:0];
                `L2DM_MIRROR_CTRL: mirror_en <= wr_val[0];
                default: ;
            endcase
        end
    end

    // forwarding decision for one packet
    // the whole decision is one combinational pass over the sampled fields; the order
    // of the steps below matters: the vlan clear runs first so the supervisor route
    // survives it, copies follow, then the two masks and the discard, so a learning or deny
    // mask can also suppress a copy that software aimed at a masked port
    // port numbers of 58 and above in any target register add nothing to the map
    always @* begin
        pmode = (i_pkt_rx_port < 6'd61) ? mode_tab[i_pkt_rx_port] : 4'h0;
        // ports beyond the table keep their own number
        next_lport = (i_pkt_rx_port < 6'd52) ? lport_tab[i_pkt_rx_port] : i_pkt_rx_port;
        hit_res = 32'h0;
        next_found = 1'b0;
        if (hit0) begin
            next_found = 1'b1;
            hit_res = res0[i_pkt_rec_idx];
        end else if (hit1) begin
            next_found = 1'b1;
            hit_res = res1[i_pkt_rec_idx];
        end
        // a miss reads as no permit and no stored port, so the learning copy fires
        next_permit = next_found & hit_res[`L2DM_PERMIT_BIT];
        next_map = i_pkt_dest_map;
        // vlan mismatch: clear normal transmit ports before the copies are added
        if (next_found && i_pkt_dest_known && i_pkt_vlan_mismatch) begin
            next_map[`L2DM_SU_FIRST-1:0] = {`L2DM_SU_FIRST{1'b0}};
            if (pmode[`L2DM_SUPR_BIT])
                next_map = next_map | l2dm_bit(sup_port);
        end
        // comparison uses the logical port so aggregate members do not move
        if (!next_found || hit_res[`L2DM_SPORT_LSB +: 6] != next_lport)
            next_map = next_map | l2dm_bit(learn_port);
        if (mirror_en && (rx_mirrored || i_pkt_tx_mirror))
            next_map = next_map | l2dm_bit(mirror_port);
        if (pmode[`L2DM_USNP_BIT] && i_pkt_tcp_valid && i_pkt_tcp_dport == user_port)
            next_map = next_map | l2dm_bit(snoop_port);
        if (pmode[`L2DM_IGMP_BIT] && i_pkt_igmp)
            next_map = next_map | l2dm_bit(igmp_port);
        // removals come last so no copy can reopen a masked port
        if (i_pkt_learning)
            next_map = next_map & ~learn_mask;
        if (i_pkt_src_deny)
            next_map = next_map & ~deny_mask;
        // discard overrides every copy, learning included: an unknown source on a
        // locked port must not reach software either
        next_discard = pmode[`L2DM_DISC_BIT] & ~next_found;
        if (next_discard)
            next_map = 58'h0;
    end

    // packet output stage
    // results are held between packets so a slow consumer can sample them after the
    // valid pulse; only o_pkt_valid returns to zero
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pkt_valid <= 1'b0;
            o_pkt_dest_map <= `L2DM_RST_MASK;
            o_pkt_logical_port <= `L2DM_RST_PORT;
            o_pkt_src_found <= 1'b0;
            o_pkt_src_permit <= 1'b0;
            o_pkt_discard <= 1'b0;
        end else begin
            o_pkt_valid <= i_pkt_valid;
            if (i_pkt_valid) begin
                o_pkt_dest_map <= next_map;
                o_pkt_logical_port <= next_lport;
                o_pkt_src_found <= next_found;
                o_pkt_src_permit <= next_permit;
                o_pkt_discard <= next_discard;
            end
        end
    end

    // empty-map counter
    // the increment looks at next_map, the final map after masks and discard, so a
    // packet dropped for an unknown source is counted as well
    // a software write to the counter in the same cycle as an empty packet loses that one count
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn)
            nodest_cnt <= `L2DM_RST_CNT;
        else if (wr_go && a == `L2DM_NODEST_CNT)
            nodest_cnt <= wr_val[27:0];
        else if (i_pkt_valid && next_map == 58'h0)
            nodest_cnt <= nodest_cnt + 28'h1;
    end

endmodule // l2dm_post

//--- l2dm_post_props.sv
`timescale 1ns/1ps
module l2dm_post_props (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rstn,
    // register bus
    input wire i_avs_read,
    input wire i_avs_write,
    input wire o_avs_waitrequest,
    // packet path
    input wire i_pkt_valid,
    input wire [5:0] i_pkt_rx_port,
    input wire o_pkt_valid,
    input wire [57:0] o_pkt_dest_map,
    input wire [5:0] o_pkt_logical_port,
    input wire o_pkt_src_found,
    input wire o_pkt_discard
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    AST_ONE_WAIT: assert property ($rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("bus access not answered after one wait cycle");
    AST_IDLE_NO_WAIT: assert property (!(i_avs_read | i_avs_write) |-> !o_avs_waitrequest)
        else $error("waitrequest high without a request");
    AST_OUT_FOLLOWS: assert property (i_pkt_valid |=> o_pkt_valid)
        else $error("packet result missing one cycle after input");
    AST_NO_SPURIOUS: assert property (!i_pkt_valid |=> !o_pkt_valid)
        else $error("packet result without an input packet");
    AST_HOLD: assert property (!i_pkt_valid |=> $stable({o_pkt_dest_map, o_pkt_logical_port, o_pkt_discard}))
        else $error("packet outputs changed without a packet");
    AST_DISC_EMPTY: assert property (o_pkt_valid && o_pkt_discard |-> o_pkt_dest_map == 58'h0)
        else $error("discarded packet keeps destinations");
    AST_DISC_UNKNOWN: assert property (o_pkt_valid && o_pkt_discard |-> !o_pkt_src_found)
        else $error("known source discarded");
    AST_LPORT_SELF: assert property (i_pkt_valid && i_pkt_rx_port >= 6'd52 |=>
        o_pkt_logical_port == $past(i_pkt_rx_port))
        else $error("untranslated port did not keep its number");
endmodule // l2dm_post_props
bind l2dm_post l2dm_post_props props_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .i_pkt_valid(i_pkt_valid),
    .i_pkt_rx_port(i_pkt_rx_port), .o_pkt_valid(o_pkt_valid), .o_pkt_dest_map(o_pkt_dest_map),
    .o_pkt_logical_port(o_pkt_logical_port), .o_pkt_src_found(o_pkt_src_found), .o_pkt_discard(o_pkt_discard));

//--- l2dm_lookup_model.sv
`timescale 1ns/1ps
module l2dm_lookup_model (
    // clock
    input wire i_ref_clk,
    // packet towards post-processing
    output reg o_valid = 1'b0,
    output reg [5:0] o_rx_port = 6'h00,
    output reg [47:0] o_src_addr = 48'h0,
    output reg [57:0] o_dest_map = 58'h0,
    output reg [6:0] o_flags = 7'h00,
    output reg [15:0] o_tcp_dport = 16'h0
);
    // flags: deny, learning, dest known, vlan mismatch, tx mirror, igmp, tcp valid
    task send(input [5:0] rx, input [47:0] src, input [57:0] map, input [6:0] f, input [15:0] dp);
        begin
            o_valid <= 1'b1;
            o_rx_port <= rx;
            o_src_addr <= src;
            o_dest_map <= map;
            o_flags <= f;
            o_tcp_dport <= dp;
            @(posedge i_ref_clk);
            o_valid <= 1'b0;
            // fields are meaningless outside the valid cycle, so do not leave address, map and flags looking right
            o_src_addr <= ~src;
            o_dest_map <= ~map;
            o_flags <= ~f;
            @(posedge i_ref_clk);
        end
    endtask
endmodule // l2dm_lookup_model

//--- l2dm_post_tb.sv
`timescale 1ns/1ps
`include "l2dm_defs.vh"
module l2dm_post_tb;
    reg i_ref_clk = 1'b0;
    reg i_rstn = 1'b0;
    reg [19:0] adr = 20'h0;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wdat = 32'h0;
    wire [31:0] rdat;
    wire wreq, pv, ov, ofound, opermit, odisc;
    wire [5:0] prx, olport;
    wire [47:0] psrc;
    wire [57:0] pmap, omap;
    wire [6:0] pf;
    wire [15:0] pdport;
    reg [66:0] expq[$];
    reg [31:0] seed = 32'h00017e02;
    reg [31:0] q;
    reg [57:0] m;
    integer num_errors = 0, total_checks = 0, cyc = 0;
    localparam [47:0] SA = 48'h0a0b0c0d0e0f;
    localparam [47:0] SB = 48'h0a0b0c0d0e00;
    localparam [57:0] B49 = 58'h1 << 49;
    localparam [57:0] B50 = 58'h1 << 50;
    localparam [57:0] LM = {10'h3ff, 48'h0};
    localparam [57:0] B55 = 58'h1 << 55;
    localparam [57:0] B56 = 58'h1 << 56;
    localparam [57:0] B57 = 58'h1 << 57;
    localparam [57:0] UPR = {8'hff, 50'h0};
    localparam [15:0] UP = 16'h1f90;
    // expected {logical port, found, permit, discard}
    localparam [8:0] K7 = {6'd7, 3'b110};
    localparam [8:0] U7 = {6'd7, 3'b000};
    localparam [8:0] K0 = {6'd0, 3'b110};
    localparam [8:0] D60 = {6'd60, 3'b001};
    always #5 i_ref_clk = ~i_ref_clk;
    l2dm_post dut_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_pkt_valid(pv), .i_pkt_rx_port(prx), .i_pkt_rec_idx(12'h000),
        .i_pkt_src_addr(psrc), .i_pkt_dest_map(pmap), .i_pkt_src_deny(pf[6]), .i_pkt_learning(pf[5]),
        .i_pkt_dest_known(pf[4]), .i_pkt_vlan_mismatch(pf[3]), .i_pkt_tx_mirror(pf[2]), .i_pkt_igmp(pf[1]),
        .i_pkt_tcp_valid(pf[0]), .i_pkt_tcp_dport(pdport), .o_pkt_valid(ov), .o_pkt_dest_map(omap),
        .o_pkt_logical_port(olport), .o_pkt_src_found(ofound), .o_pkt_src_permit(opermit), .o_pkt_discard(odisc));
    l2dm_lookup_model lk_u (.i_ref_clk(i_ref_clk), .o_valid(pv), .o_rx_port(prx), .o_src_addr(psrc),
        .o_dest_map(pmap), .o_flags(pf), .o_tcp_dport(pdport));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input [71:0] g, input [71:0] e);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks=%0d mismatches=%0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task bus(input w, input [19:0] a, input [31:0] d);
        begin
            rd <= !w;
            wr <= w;
            adr <= a;
            wdat <= d;
            @(posedge i_ref_clk);
            while (wreq !== 1'b0)
                @(posedge i_ref_clk);
            q = rdat;
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge i_ref_clk);
        end
    endtask
    task rchk(input [19:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            chk({40'h0, q}, {40'h0, e});
        end
    endtask
    task pkt(input [5:0] rx, input [47:0] src, input [6:0] f, input [8:0] x, input [57:0] e);
        begin
            expq.push_back({x, e});
            seed = lfsr(seed);
            lk_u.send(rx, src, m, f, f[0] ? UP : seed[15:0]);
        end
    endtask
    // results are matched in arrival order against the notes left by the driver
    always @(posedge i_ref_clk) begin
        cyc = cyc + 1;
        if (ov === 1'b1) begin
            if (expq.size() == 0)
                chk(72'h1, 72'h0);
            else
                chk({5'h0, olport, ofound, opermit, odisc, omap}, {5'h0, expq.pop_front()});
        end
        if (cyc == 3000) begin
            num_errors = num_errors + 1;
            conclude;
        end
    end
    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        @(posedge i_ref_clk);
        rchk(`L2DM_NODEST_CNT, 32'h0);
        rchk(`L2DM_DENY_LO, 32'h0);
        rchk(`L2DM_MODE_BASE, 32'h0);
        bus(1'b1, 20'hc46f0, 32'hffffffff);
        rchk(20'hc46f0, 32'h0);
        bus(1'b1, `L2DM_LEARN_PORT, 32'hffffffb2);
        rchk(`L2DM_LEARN_PORT, 32'h32);
        $display("test registers done");
        bus(1'b1, `L2DM_KEY_BASE, 32'h80000a0b);
        bus(1'b1, `L2DM_KEY_BASE + 20'h4, 32'h0c0d0e0f);
        bus(1'b1, `L2DM_KEY_BASE + 20'h8, 32'h0);
        bus(1'b1, `L2DM_KEY_BASE + 20'h10, 32'h008e0000);
        bus(1'b1, `L2DM_KEY_BASE + 20'h14, 32'h0);
        bus(1'b1, `L2DM_LPORT_BASE + 20'h14, 32'h7);
        seed = lfsr(seed);
        m = {seed[25:0], lfsr(seed)};
        m[50] = 1'b0;
        m[49] = 1'b0;
        pkt(6'd5, SA, 7'h00, K7, m);
        pkt(6'd5, SB, 7'h00, U7, m | B50);
        pkt(6'd6, SA, 7'h00, K0, m | B50);
        $display("test learning copy done");
        bus(1'b1, `L2DM_DENY_LO, 32'h0000ffff);
        bus(1'b1, `L2DM_LMASK_HI, 32'h03ff0000);
        pkt(6'd5, SA, 7'h40, K7, m & ~58'hffff);
        pkt(6'd5, SA, 7'h20, K7, m & ~LM);
        pkt(6'd5, SB, 7'h60, U7, m & ~58'hffff & ~LM);
        $display("test masks done");
        bus(1'b1, `L2DM_MIRROR_CTRL, 32'h1);
        bus(1'b1, `L2DM_MIRROR_PORT, 32'h31);
        bus(1'b1, `L2DM_SMIR_LO, 32'h20);
        rchk(`L2DM_SMIR_LO, 32'h20);
        pkt(6'd5, SA, 7'h00, K7, m | B49);
        pkt(6'd4, SA, 7'h04, K0, m | B49 | B50);
        $display("test mirror done");
        pkt(6'd5, SA, 7'h18, K7, (m & UPR) | B49);
        pkt(6'd5, SA, 7'h03, K7, m | B49);
        bus(1'b1, `L2DM_MODE_BASE + 20'h14, 32'h7);
        bus(1'b1, `L2DM_SUP_PORT, 32'h38);
        bus(1'b1, `L2DM_USER_PORT, {16'h0, UP});
        bus(1'b1, `L2DM_SNOOP_PORT, 32'h39);
        bus(1'b1, `L2DM_IGMP_PORT, 32'h37);
        pkt(6'd5, SA, 7'h18, K7, (m & UPR) | B56 | B49);
        pkt(6'd5, SA, 7'h01, K7, m | B57 | B49);
        pkt(6'd5, SA, 7'h02, K7, m | B55 | B49);
        $display("test supervisor copies done");
        bus(1'b1, `L2DM_MODE_BASE + 20'hf0, 32'h8);
        pkt(6'd60, SB, 7'h00, D60, 58'h0);
        rchk(`L2DM_NODEST_CNT, 32'h1);
        bus(1'b1, `L2DM_NODEST_CNT, 32'h0fffffff);
        pkt(6'd60, SB, 7'h00, D60, 58'h0);
        rchk(`L2DM_NODEST_CNT, 32'h0);
        $display("test discard and count done");
        chk(expq.size(), 72'h0);
        conclude;
    end
endmodule // l2dm_post_tb
